// ==== include/pin_mode_defs.svh ====
// offsets, field layout and reset values for the pin-mode registers
`ifndef PIN_MODE_DEFS_SVH
`define PIN_MODE_DEFS_SVH
`define PIN_MODE_ADDR_W      4
`define PIN_MODE_DATA_W      16
`define PORT_B_PIN_MODE_OFS  4'h0
`define PORT_C_PIN_MODE_OFS  4'h2
`define PORT_D_PIN_MODE_OFS  4'h4
`define PIN_MODE_RESET       16'h0000
`define PIN_MODE_FIELD_W     2
`define PINS_PER_PORT        8
`define UNMAPPED_READ        16'h0000
`endif

// ==== include/pin_mode_pkg.sv ====
// types shared by the pin-function selection logic
package pin_mode_pkg;
  typedef enum logic [1:0] {
    MODE_ALT     = 2'b00,
    MODE_OUT     = 2'b01,
    MODE_IN_PU   = 2'b10,
    MODE_IN_NOPU = 2'b11
  } pin_mode_e;
endpackage

// ==== verilog/pin_port_decode.sv ====
// per-port decode of eight 2-bit mode fields into pin steering
`timescale 1ns/10ps
`default_nettype none
`include "pin_mode_defs.svh"
module pin_port_decode (
  input  wire logic [15:0] mode_word,     // port mode register contents
  input  wire logic [7:0]  alt_out,       // peripheral output values
  input  wire logic [7:0]  alt_oe,        // peripheral output enables
  input  wire logic [7:0]  gpio_out,      // port data output values
  output logic      [7:0]  pad_out,       // value toward the pad
  output logic      [7:0]  pad_oe,        // pad driver enable
  output logic      [7:0]  pad_pullup,    // pull-up enable
  output logic      [7:0]  alt_sel        // pin handed to peripheral
);
  // field of pin n sits at bits 2n+1:2n
  function automatic pin_mode_pkg::pin_mode_e field_of(input logic [15:0] w, input int n);
    field_of = pin_mode_pkg::pin_mode_e'(w[2*n +: `PIN_MODE_FIELD_W]);
  endfunction

  // one case per pin; a reserved code cannot exist, default keeps pin quiet
  always_comb begin
    for (int n = 0; n < `PINS_PER_PORT; n++) begin
      pad_out[n]    = 1'b0;
      pad_oe[n]     = 1'b0;
      pad_pullup[n] = 1'b0;
      alt_sel[n]    = 1'b0;
      case (field_of(mode_word, n))
        pin_mode_pkg::MODE_ALT: begin
          alt_sel[n] = 1'b1;
          pad_out[n] = alt_out[n];
          pad_oe[n]  = alt_oe[n];
        end
        pin_mode_pkg::MODE_OUT: begin
          pad_out[n] = gpio_out[n];
          pad_oe[n]  = 1'b1;
        end
        pin_mode_pkg::MODE_IN_PU: begin
          pad_pullup[n] = 1'b1;
        end
        pin_mode_pkg::MODE_IN_NOPU: begin
          pad_pullup[n] = 1'b0;
        end
        default: begin
          pad_oe[n] = 1'b0;
        end
      endcase
    end
  end
endmodule // pin_port_decode
`default_nettype wire

// ==== verilog/port_pin_function_select.sv ====
// pin-function selection registers and steering for ports b, c and d
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pin_mode_defs.svh"
module port_pin_function_select (
  input  wire logic        core_clk,        // system clock
  input  wire logic        reset,           // synchronous, active high
  input  wire logic [3:0]  reg_addr,        // register offset
  input  wire logic [15:0] reg_wdata,       // write data
  input  wire logic        reg_wr,          // write strobe
  input  wire logic        reg_rd,          // read strobe
  output logic      [15:0] reg_rdata,       // read data, cycle after strobe
  input  wire logic [23:0] alt_out,         // peripheral outputs, b[7:0] c d
  input  wire logic [23:0] alt_oe,          // peripheral output enables
  input  wire logic [23:0] gpio_out,        // port data outputs
  output logic      [23:0] pad_out,         // pad output values
  output logic      [23:0] pad_oe,          // pad driver enables
  output logic      [23:0] pad_pullup,      // pull-up enables
  output logic      [23:0] alt_sel          // pins given to peripherals
);
  typedef struct packed {
    logic [15:0] port_b_pin_mode;
    logic [15:0] port_c_pin_mode;
    logic [15:0] port_d_pin_mode;
    logic [15:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // decode and write path; unmapped reads return zero, writes ignored
  always_comb begin
    state_nxt       = state_r;
    state_nxt.rdata = `UNMAPPED_READ;
    if (reg_wr) begin
      case (reg_addr)
        `PORT_B_PIN_MODE_OFS: state_nxt.port_b_pin_mode = reg_wdata;
        `PORT_C_PIN_MODE_OFS: state_nxt.port_c_pin_mode = reg_wdata;
        `PORT_D_PIN_MODE_OFS: state_nxt.port_d_pin_mode = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `PORT_B_PIN_MODE_OFS: state_nxt.rdata = state_r.port_b_pin_mode;
        `PORT_C_PIN_MODE_OFS: state_nxt.rdata = state_r.port_c_pin_mode;
        `PORT_D_PIN_MODE_OFS: state_nxt.rdata = state_r.port_d_pin_mode;
        default:              state_nxt.rdata = `UNMAPPED_READ;
      endcase
    end
  end

  // all pins come out of reset in peripheral mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r.port_b_pin_mode <= `PIN_MODE_RESET;
      state_r.port_c_pin_mode <= `PIN_MODE_RESET;
      state_r.port_d_pin_mode <= `PIN_MODE_RESET;
      state_r.rdata           <= `UNMAPPED_READ;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;

  // steering is combinational so a mode change acts the cycle after the write
  pin_port_decode u_port_b (
    .mode_word  (state_r.port_b_pin_mode),
    .alt_out    (alt_out[7:0]),
    .alt_oe     (alt_oe[7:0]),
    .gpio_out   (gpio_out[7:0]),
    .pad_out    (pad_out[7:0]),
    .pad_oe     (pad_oe[7:0]),
    .pad_pullup (pad_pullup[7:0]),
    .alt_sel    (alt_sel[7:0])
  );
  pin_port_decode u_port_c (
    .mode_word  (state_r.port_c_pin_mode),
    .alt_out    (alt_out[15:8]),
    .alt_oe     (alt_oe[15:8]),
    .gpio_out   (gpio_out[15:8]),
    .pad_out    (pad_out[15:8]),
    .pad_oe     (pad_oe[15:8]),
    .pad_pullup (pad_pullup[15:8]),
    .alt_sel    (alt_sel[15:8])
  );
  pin_port_decode u_port_d (
    .mode_word  (state_r.port_d_pin_mode),
    .alt_out    (alt_out[23:16]),
    .alt_oe     (alt_oe[23:16]),
    .gpio_out   (gpio_out[23:16]),
    .pad_out    (pad_out[23:16]),
    .pad_oe     (pad_oe[23:16]),
    .pad_pullup (pad_pullup[23:16]),
    .alt_sel    (alt_sel[23:16])
  );
endmodule // port_pin_function_select
`default_nettype wire

// ==== tb/pin_mode_monitor.sv ====
// port checks for the pin-function selector
`timescale 1ns/10ps
`default_nettype none
module pin_mode_monitor (
  input wire logic        core_clk,   // clock
  input wire logic        reset,      // sync reset
  input wire logic [3:0]  reg_addr,   // offset
  input wire logic [15:0] reg_wdata,  // wdata
  input wire logic        reg_wr,     // write
  input wire logic        reg_rd,     // read
  input wire logic [15:0] reg_rdata,  // rdata
  input wire logic [23:0] alt_out,    // periph out
  input wire logic [23:0] alt_oe,     // periph oe
  input wire logic [23:0] pad_out,    // pad value
  input wire logic [23:0] pad_oe,     // pad enable
  input wire logic [23:0] pad_pullup, // pull-up
  input wire logic [23:0] alt_sel     // periph pick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // read data must be zero outside the answer cycle
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
  reset_alt_a: assert property ($past(reset) |-> alt_sel == 24'hFFFFFF) else $error("not alt after reset");
  // a pin given away follows its peripheral on value and enable
  alt_path_a: assert property ((((pad_out ^ alt_out) | (pad_oe ^ alt_oe)) & alt_sel) == 24'h000000)
    else $error("alt path wrong");
  // pull-up only on an undriven input
  pull_in_a: assert property ((pad_pullup & (alt_sel | pad_oe | pad_out)) == 24'h000000)
    else $error("pull-up on driven pin");
  in_nopull_a: assert property (reg_wr && reg_addr == 4'h2 && reg_wdata == 16'hFFFF |=>
    (pad_oe[15:8] | pad_pullup[15:8] | alt_sel[15:8]) == 8'h00) else $error("input mode wrong");
endmodule // pin_mode_monitor
bind port_pin_function_select pin_mode_monitor u_mon (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alt_out(alt_out),
  .alt_oe(alt_oe), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt_sel(alt_sel));
`default_nettype wire

// ==== tb/port_pin_function_select_test.sv ====
// directed bench for the pin-function selector
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_select_test;
  logic        core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [23:0] alt_out = 24'h5A3C96, alt_oe = 24'hC3A50F, gpio_out = 24'h3CF0A5;
  logic [23:0] pad_out, pad_oe, pad_pullup, alt_sel;
  int          num_errors = 0, n_tests = 0;
  port_pin_function_select uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alt_out(alt_out), .alt_oe(alt_oe),
    .gpio_out(gpio_out), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt_sel(alt_sel));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // strobes launched on the edge; results sampled mid-cycle once settled
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge core_clk);
    if (!w) chk("rdata", {8'h00, d}, {8'h00, reg_rdata});
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // every mode on every port, then a mixed word and an unmapped offset
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk("reset pins", {24'hFFFFFF}, alt_sel);
    for (int p = 0; p < 3; p++) begin
      acc(1'b0, 4'(2 * p), 16'h0000);
      for (int m = 0; m < 4; m++) begin
        acc(1'b1, 4'(2 * p), {8{2'(m)}});
        acc(1'b0, 4'(2 * p), {8{2'(m)}});
        chk("pins", {m == 0 ? 8'hFF : 8'h00, m == 0 ? alt_oe[8*p +: 8] : {8{m == 1}},
          m == 0 ? alt_out[8*p +: 8] : m == 1 ? gpio_out[8*p +: 8] : 8'h00},
          {alt_sel[8*p +: 8], pad_oe[8*p +: 8], pad_out[8*p +: 8]});
        chk("pullup", {16'h0000, {8{m == 2}}}, {16'h0000, pad_pullup[8*p +: 8]});
      end
    end
    acc(1'b1, 4'h0, 16'h00E4);
    chk("field order", {12'h001, 4'b0100, 6'h00, 1'b1, alt_oe[0]},
      {8'h00, alt_sel[3:0], pad_pullup[3:0], 4'h0, pad_oe[3:0]});
    acc(1'b1, 4'h6, 16'hFFFF);
    acc(1'b0, 4'h6, 16'h0000);
    acc(1'b0, 4'h0, 16'h00E4);
    test_done();
  end
endmodule // port_pin_function_select_test
`default_nettype wire
